/* shared/codec_port_pkg.sv */
// Constants and types for the codec host register port
// Operation
// - Sixteen-bit down timer reloads from low and high byte registers.
// - Timer enable loads count, then decrements once per ten microsecond tick.
// - Count reaching zero sets timer flag and raises the internal interrupt.
// - Next tick after zero reloads count and keeps counting.
// - Timer flag clears on any status write or writing zero to it.
// - Any count rollover sets status interrupt until status write or source clears.
// - Interrupt pin held low while pin enable is clear; flag still tracks.
// - Capture overrun keeps last whole sample; no overwrite during transfer.
// - Playback underrun repeats last sample unless zero select; resume on next sample.
// - Two address pins select four byte-wide direct registers.
// - Index register picks one of 32 indirect registers for the data window.
// - Reset gives compatibility mode; extended mode bit opens indices 16 to 31.
// - Format and config writes need unlock bit, except config run bits 1:0; DAC muted while unlocked.
// - Request inhibit bit gates DMA requests on the status interrupt flag.
// - During init writes ignored, reads return 80h; init bit reads one.
// - After init, index register reads 010x0000.
// - Data port writes go to playback register, reads come from capture.
// - Capture reads step byte pointer, hold at last; rewind on new sample plus status read.
// - Playback ready bit is one when playback register accepts more data.
// - Playback writes step pointer; extra writes ignored; reset when sample sent.
// - Sample error bit set on capture overrun or playback underrun.
package codec_port_pkg;
    localparam logic [1:0] ADDR_INDEX    = 2'h0;
    localparam logic [1:0] ADDR_WINDOW   = 2'h1;
    localparam logic [1:0] ADDR_STATUS   = 2'h2;
    localparam logic [1:0] ADDR_DATA     = 2'h3;
    localparam logic [4:0] IDX_FORMAT    = 5'h08;
    localparam logic [4:0] IDX_CONFIG    = 5'h09;
    localparam logic [4:0] IDX_PINCTL    = 5'h0a;
    localparam logic [4:0] IDX_ERRSTAT   = 5'h0b;
    localparam logic [4:0] IDX_MODEID    = 5'h0c;
    localparam logic [4:0] IDX_FEATEN    = 5'h10;
    localparam logic [4:0] IDX_TMR_LO    = 5'h14;
    localparam logic [4:0] IDX_TMR_HI    = 5'h15;
    localparam logic [4:0] IDX_FEATSTAT  = 5'h18;
    localparam logic [4:0] IDX_CAPFMT    = 5'h1c;
    localparam int         BIT_INIT      = 7;
    localparam int         BIT_UNLOCK    = 6;
    localparam int         BIT_INHIBIT   = 5;
    localparam int         BIT_IDX_HIGH  = 4;
    localparam int         BIT_CAP_RUN   = 1;
    localparam int         BIT_PLAY_RUN  = 0;
    localparam int         BIT_IRQ_EN    = 1;
    localparam int         BIT_EXT_MODE  = 6;
    localparam int         BIT_TMR_RUN   = 6;
    localparam int         BIT_ZERO_SEL  = 0;
    localparam int         BIT_TI        = 6;
    localparam int         BIT_CI        = 5;
    localparam int         BIT_PI        = 4;
    localparam int         BIT_CAP_OVR   = 2;
    localparam int         BIT_PLAY_UND  = 0;
    localparam logic [7:0] INIT_READ     = 8'h80;
    localparam logic [7:0] INDEX_RESET   = 8'h40;
    localparam logic [7:0] MODEID_RESET  = 8'h8a;  // Identity bits arbitrary
    localparam logic [7:0] RESERVED_READ = 8'h00;
    localparam int         CLK_MHZ       = 200;
    localparam int         TICK_US       = 10;
    localparam int         TICK_CYCLES   = CLK_MHZ * TICK_US;
    localparam int         INIT_CYCLES   = 64;
    localparam int         SAMPLE_BYTES  = 4;
    typedef enum logic [2:0] {
        ST_INIT  = 3'b001,
        ST_RUN   = 3'b010,
        ST_POWER = 3'b100
    } port_state_e;
endpackage

/* hw/codec_host_port.sv */
// Host register port with timer, interrupt flag and PIO data paths
`timescale 1ns/1ps
module codec_host_port #(
    parameter int TICK_DIV   = codec_port_pkg::TICK_CYCLES,
    parameter int INIT_COUNT = codec_port_pkg::INIT_CYCLES
) (
    input  wire logic        clock_in,
    input  wire logic        reset_n_in,
    input  wire logic [1:0]  addr_in,
    input  wire logic        cs_n_in,
    input  wire logic        rd_n_in,
    input  wire logic        wr_n_in,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe_out,
    output logic             irq_out,
    output logic             playback_dma_request_out,
    output logic             capture_dma_request_out,
    input  wire logic        playback_dma_ack_in,
    input  wire logic        capture_dma_ack_in,
    input  wire logic        power_down_in,
    input  wire logic        adc_valid_in,
    output logic             adc_ready_out,
    input  wire logic [31:0] adc_sample_in,
    input  wire logic        dac_strobe_in,
    output logic      [31:0] dac_sample_out,
    output logic             dac_mute_out,
    output logic             playback_wrap_out
);
    import codec_port_pkg::*;

    localparam int PTR_W = $clog2(SAMPLE_BYTES + 1);

    typedef struct packed {
        port_state_e        state;
        logic [15:0]        init_cnt;
        logic [2:0]         cs_s1;
        logic [2:0]         cs_s2;
        logic [2:0]         cs_s3;
        logic [1:0]         addr_s1;
        logic [1:0]         addr_s2;
        logic [7:0]         din_s1;
        logic [7:0]         din_s2;
        logic [1:0]         ack_s1;
        logic [1:0]         ack_s2;
        logic               pd_s1;
        logic               pd_s2;
        logic [7:0]         index;
        logic [7:0]         format;
        logic [7:0]         config_r;
        logic [7:0]         pinctl;
        logic [7:0]         modeid;
        logic [7:0]         featen;
        logic [7:0]         capfmt;
        logic [7:0]         tmr_lo;
        logic [7:0]         tmr_hi;
        logic [15:0]        tmr_cnt;
        logic               tmr_loaded;
        logic               tmr_zero;
        logic [15:0]        pre_cnt;
        logic               flag_ti;
        logic               flag_ci;
        logic               flag_pi;
        logic               cap_ovr;
        logic               play_und;
        logic [1:0][31:0]   cap_buf;
        logic [7:0][7:0]    mixer;
        logic [1:0]         cap_vld;
        logic               cap_rd;
        logic [PTR_W-1:0]   cap_ptr;
        logic               cap_new;
        logic [31:0]        play_buf;
        logic [PTR_W-1:0]   play_ptr;
        logic [31:0]        dac_hold;
        logic [15:0]        play_cnt;
        logic [15:0]        cap_cnt;
        logic [7:0]         rdata;
        logic               oe;
        logic               irq;
        logic               playback_dma_request;
        logic               capture_dma_request;
        logic               wrap;
        logic               adc_rdy;
    } state_s;

    state_s cur;
    state_s nxt;

    // Byte lane of a 32-bit word
    function automatic logic [7:0] lane(input logic [31:0] w, input logic [PTR_W-1:0] p);
        lane = w[8*p[1:0] +: 8];
    endfunction

    // Write gate for unlock-protected indices
    function automatic logic guarded(input logic [4:0] idx);
        guarded = (idx == IDX_FORMAT) || (idx == IDX_CONFIG) || (idx == IDX_CAPFMT);
    endfunction

    logic       wr_edge;
    logic       rd_edge;
    logic [4:0] eff_idx;
    logic       int_flag;
    logic       tick;
    logic [7:0] ind_rd;
    logic       run;
    logic       ovr_evt;

    // Strobe edges, effective index and interrupt summary
    always_comb begin
        run      = cur.state == ST_RUN;
        wr_edge  = cur.cs_s2[1] && !cur.cs_s3[1];
        rd_edge  = cur.cs_s2[0] && !cur.cs_s3[0];
        eff_idx  = {cur.modeid[BIT_EXT_MODE] & cur.index[BIT_IDX_HIGH], cur.index[3:0]};
        int_flag = cur.flag_ti | cur.flag_ci | cur.flag_pi;
        tick     = cur.pre_cnt == 16'(TICK_DIV - 1);
        ovr_evt  = adc_valid_in && !cur.capfmt[BIT_CAP_RUN] && cur.config_r[BIT_CAP_RUN] &&
                   cur.cap_vld[1];
        unique case (eff_idx)
            IDX_FORMAT:   ind_rd = cur.format;
            IDX_CONFIG:   ind_rd = cur.config_r;
            IDX_PINCTL:   ind_rd = cur.pinctl;
            IDX_ERRSTAT:  ind_rd = {2'h0, cur.play_und, cur.cap_ovr, 4'h0};
            IDX_MODEID:   ind_rd = cur.modeid;
            IDX_FEATEN:   ind_rd = cur.featen;
            IDX_TMR_LO:   ind_rd = cur.tmr_lo;
            IDX_TMR_HI:   ind_rd = cur.tmr_hi;
            IDX_FEATSTAT: ind_rd = {1'b0, cur.flag_ti, cur.flag_ci, cur.flag_pi,
                                    2'h0, cur.cap_ovr, cur.play_und};
            IDX_CAPFMT:   ind_rd = cur.capfmt;
            default:      ind_rd = RESERVED_READ;
        endcase
        if (eff_idx[4:3] == 2'b00) ind_rd = cur.mixer[eff_idx[2:0]];
    end

    // Next-state logic
    always_comb begin
        nxt         = cur;
        nxt.cs_s1   = {~cs_n_in & ~wr_n_in, ~cs_n_in & ~rd_n_in, 1'b0} >> 1 |
                      {1'b0, ~cs_n_in & ~wr_n_in, ~cs_n_in & ~rd_n_in};
        nxt.cs_s2   = cur.cs_s1;
        nxt.cs_s3   = cur.cs_s2;
        nxt.addr_s1 = addr_in;
        nxt.addr_s2 = cur.addr_s1;
        nxt.din_s1  = data_in;
        nxt.din_s2  = cur.din_s1;
        nxt.ack_s1  = {capture_dma_ack_in, playback_dma_ack_in};
        nxt.ack_s2  = cur.ack_s1;
        nxt.pd_s1   = power_down_in;
        nxt.pd_s2   = cur.pd_s1;
        nxt.wrap    = 1'b0;
        nxt.oe      = cur.cs_s2[0];

        // Init and power-down sequencing
        unique case (cur.state)
            ST_INIT: begin
                nxt.init_cnt = cur.init_cnt + 16'h1;
                if (cur.init_cnt == 16'(INIT_COUNT - 1)) begin
                    nxt.state = ST_RUN;
                    nxt.index = INDEX_RESET;
                end
            end
            ST_RUN: if (cur.pd_s2) nxt.state = ST_POWER;
            ST_POWER: if (!cur.pd_s2) begin
                nxt.state    = ST_INIT;
                nxt.init_cnt = 16'h0;
            end
        endcase

        // Timer prescaler and down counter
        nxt.pre_cnt = tick ? 16'h0 : cur.pre_cnt + 16'h1;
        if (!cur.featen[BIT_TMR_RUN]) begin
            nxt.tmr_loaded = 1'b0;
        end else if (!cur.tmr_loaded || (tick && cur.tmr_zero)) begin
            nxt.tmr_cnt    = {cur.tmr_hi, cur.tmr_lo};
            nxt.tmr_loaded = 1'b1;
            nxt.tmr_zero   = 1'b0;
        end else if (tick && !cur.tmr_zero) begin
            nxt.tmr_cnt = cur.tmr_cnt - 16'h1;
            nxt.tmr_zero = cur.tmr_cnt == 16'h1;
        end

        // Capture buffer fill from converter, two entries deep
        if (adc_valid_in && cur.capfmt[BIT_CAP_RUN] == 1'b0 && cur.config_r[BIT_CAP_RUN]) begin
            if (!cur.cap_vld[1]) begin
                nxt.cap_buf[cur.cap_vld[0] ? 1 : 0] = adc_sample_in;
                nxt.cap_vld = {cur.cap_vld[0], 1'b1};
                nxt.cap_new = 1'b1;
            end else begin
                nxt.cap_ovr = 1'b1;
            end
        end

        // Host accesses
        if (run && wr_edge) begin
            unique case (cur.addr_s2)
                ADDR_INDEX: nxt.index = {1'b0, cur.din_s2[6:5],
                                         cur.modeid[BIT_EXT_MODE] & cur.din_s2[4], cur.din_s2[3:0]};
                ADDR_WINDOW: begin
                    if (!guarded(eff_idx) || cur.index[BIT_UNLOCK]) begin
                        unique case (eff_idx)
                            IDX_FORMAT:  nxt.format = cur.din_s2;
                            IDX_CAPFMT:  nxt.capfmt = cur.din_s2;
                            IDX_PINCTL:  nxt.pinctl = cur.din_s2;
                            IDX_MODEID:  nxt.modeid[BIT_EXT_MODE] = cur.din_s2[BIT_EXT_MODE];
                            IDX_FEATEN:  nxt.featen = cur.din_s2;
                            IDX_TMR_LO:  nxt.tmr_lo = cur.din_s2;
                            IDX_TMR_HI:  nxt.tmr_hi = cur.din_s2;
                            default: ;
                        endcase
                    end
                    if (eff_idx[4:3] == 2'b00) nxt.mixer[eff_idx[2:0]] = cur.din_s2;
                    if (eff_idx == IDX_CONFIG) begin
                        nxt.config_r[1:0] = cur.din_s2[1:0];
                        if (cur.index[BIT_UNLOCK]) nxt.config_r = cur.din_s2;
                    end
                    if (eff_idx == IDX_FEATSTAT) begin
                        nxt.flag_ti  = cur.flag_ti & cur.din_s2[BIT_TI];
                        nxt.flag_ci  = cur.flag_ci & cur.din_s2[BIT_CI];
                        nxt.flag_pi  = cur.flag_pi & cur.din_s2[BIT_PI];
                        nxt.cap_ovr  = (cur.cap_ovr & cur.din_s2[BIT_CAP_OVR]) | ovr_evt;
                        nxt.play_und = cur.play_und & cur.din_s2[BIT_PLAY_UND];
                    end
                end
                ADDR_STATUS: begin
                    nxt.flag_ti = 1'b0;
                    nxt.flag_ci = 1'b0;
                    nxt.flag_pi = 1'b0;
                end
                ADDR_DATA: if (cur.play_ptr != PTR_W'(SAMPLE_BYTES)) begin
                    nxt.play_buf[8*cur.play_ptr[1:0] +: 8] = cur.din_s2;
                    nxt.play_ptr = cur.play_ptr + PTR_W'(1);
                end
            endcase
        end
        if (run && rd_edge) begin
            if (cur.addr_s2 == ADDR_DATA && cur.cap_ptr != PTR_W'(SAMPLE_BYTES - 1))
                nxt.cap_ptr = cur.cap_ptr + PTR_W'(1);
            if (cur.addr_s2 == ADDR_STATUS && cur.cap_new && cur.cap_vld[0]) begin
                nxt.cap_ptr = '0;
                nxt.cap_new = 1'b0;
                nxt.cap_rd  = 1'b1;
            end
        end

        // Read data mux, 80h outside normal operation
        if (!run) nxt.rdata = INIT_READ;
        else if (rd_edge) begin
            unique case (cur.addr_s2)
                ADDR_INDEX:  nxt.rdata = {1'b0, cur.index[6:0]};
                ADDR_WINDOW: nxt.rdata = ind_rd;
                ADDR_STATUS: nxt.rdata = {1'b0, 1'b0, cur.cap_vld[0], cur.cap_ovr | cur.play_und,
                                          2'h0, cur.play_ptr != PTR_W'(SAMPLE_BYTES), int_flag};
                ADDR_DATA:   nxt.rdata = lane(cur.cap_buf[0], cur.cap_ptr);
            endcase
        end

        // Capture and playback DMA transfers and rollover; retire capture sample after transfer
        if (cur.ack_s2[1] && cur.cap_vld[0]) begin
            nxt.cap_buf[0] = nxt.cap_buf[1];
            nxt.cap_vld    = {1'b0, nxt.cap_vld[1]};
            if (cur.cap_cnt == 16'h0) nxt.flag_ci = 1'b1;
            nxt.cap_cnt = cur.cap_cnt - 16'h1;
        end
        if (cur.ack_s2[0]) begin
            if (cur.play_cnt == 16'h0) nxt.flag_pi = 1'b1;
            nxt.play_cnt = cur.play_cnt - 16'h1;
        end
        // Sample clock to DAC: new sample, or on underrun repeat or zero
        if (dac_strobe_in) begin
            if (cur.play_ptr == PTR_W'(SAMPLE_BYTES)) begin
                nxt.dac_hold = cur.play_buf;
                nxt.play_ptr = '0;
                nxt.wrap     = 1'b1;
            end else if (cur.config_r[BIT_PLAY_RUN]) begin
                nxt.play_und = 1'b1;
                if (cur.featen[BIT_ZERO_SEL]) nxt.dac_hold = 32'h0;
            end
        end
        // Timer zero sets its flag; set beats a same-cycle clear
        if (cur.tmr_loaded && tick && cur.tmr_cnt == 16'h1) nxt.flag_ti = 1'b1;
        if (!cur.cap_rd) nxt.cap_rd = 1'b0;

        // Output registers
        nxt.irq  = cur.pinctl[BIT_IRQ_EN] & (nxt.flag_ti | nxt.flag_ci | nxt.flag_pi);
        nxt.playback_dma_request = cur.config_r[BIT_PLAY_RUN] && cur.play_ptr != PTR_W'(SAMPLE_BYTES) &&
                   !(cur.index[BIT_INHIBIT] && int_flag);
        nxt.capture_dma_request = cur.config_r[BIT_CAP_RUN] && cur.cap_vld[0] &&
                   !(cur.index[BIT_INHIBIT] && int_flag);
        nxt.adc_rdy = ~nxt.cap_vld[1];
    end

    // State register
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cur          <= '0;
            cur.state    <= ST_INIT;
            cur.index    <= INDEX_RESET;
            cur.modeid   <= MODEID_RESET & ~(8'h1 << BIT_EXT_MODE);
            cur.rdata    <= INIT_READ;
        end else begin
            cur <= nxt;
        end
    end

    // Outputs straight from the state register
    always_comb begin
        data_out                 = cur.rdata;
        data_oe_out              = cur.oe;
        irq_out                  = cur.irq;
        playback_dma_request_out = cur.playback_dma_request;
        capture_dma_request_out  = cur.capture_dma_request;
        adc_ready_out            = cur.adc_rdy;
        dac_sample_out           = cur.dac_hold;
        dac_mute_out             = cur.index[BIT_UNLOCK];
        playback_wrap_out        = cur.wrap;
    end
endmodule

/* dv/host_bus_model.sv */
// Host processor model driving the parallel register bus
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic       clock_in,
    input  wire logic [7:0] rd_data_in,
    output logic      [1:0] addr_out,
    output logic            cs_n_out,
    output logic            rd_n_out,
    output logic            wr_n_out,
    output logic      [7:0] data_out
);
    // Idle bus: strobes high, address and data lines scrambled
    initial begin
        addr_out = 2'h0;
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        data_out = 8'h5a;
    end
    // One access: strobe held six cycles, then three idle cycles
    task automatic bus_cycle(input logic wr, input logic [1:0] a, input logic [7:0] d,
                             output logic [7:0] q);
        @(posedge clock_in);
        #1;
        addr_out = a;
        data_out = d;
        cs_n_out = 1'b0;
        rd_n_out = wr;
        wr_n_out = !wr;
        repeat (6) @(posedge clock_in);
        q = rd_data_in;
        #1;
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        data_out = ~d;
        addr_out = ~a;
        repeat (3) @(posedge clock_in);
    endtask
endmodule

/* dv/codec_host_port_assertions.sv */
// Port checker for the codec host register port
`timescale 1ns/1ps
module codec_host_port_checker #(
    parameter int INIT_COUNT = 64
) (
    input wire logic       clock_in,
    input wire logic       reset_n_in,
    input wire logic       cs_n_in,
    input wire logic       rd_n_in,
    input wire logic       wr_n_in,
    input wire logic [7:0] data_out,
    input wire logic       data_oe_out,
    input wire logic       irq_out,
    input wire logic       playback_dma_request_out,
    input wire logic       adc_valid_in,
    input wire logic       adc_ready_out,
    input wire logic       dac_strobe_in,
    input wire logic       dac_mute_out,
    input wire logic       playback_wrap_out
);
    logic [7:0] age;
    logic [3:0] since_wr;
    logic [3:0] since_dac;
    // Saturating ages: since reset, last write strobe, last sample clock
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            age       <= 8'h00;
            since_wr  <= 4'hf;
            since_dac <= 4'hf;
        end else begin
            age       <= (age == 8'hff) ? age : age + 8'h01;
            since_wr  <= (!wr_n_in && !cs_n_in) ? 4'h0 : since_wr + {3'h0, since_wr != 4'hf};
            since_dac <= dac_strobe_in ? 4'h0 : since_dac + {3'h0, since_dac != 4'hf};
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    a_oe_after_read: assert property ((!cs_n_in && !rd_n_in)[*6] |-> data_oe_out)
        else $error("read strobe not answered");
    a_oe_only_reads: assert property (data_oe_out |-> !$past(rd_n_in, 2) || !$past(rd_n_in, 3) || !$past(rd_n_in, 4) || !$past(rd_n_in, 5))
        else $error("data bus driven without a read");
    a_init_reads: assert property (age < INIT_COUNT |-> data_out == 8'h80)
        else $error("init read value wrong");
    a_init_quiet: assert property (age < INIT_COUNT |-> !irq_out && !playback_dma_request_out)
        else $error("interrupt or request during init");
    a_mute_on_write: assert property ($changed(dac_mute_out) && age == 8'hff |-> since_wr < 8)
        else $error("mute changed without a host write");
    a_wrap_single: assert property (playback_wrap_out |=> !playback_wrap_out)
        else $error("wrap pulse longer than one cycle");
    a_wrap_on_clock: assert property (playback_wrap_out |-> since_dac < 8)
        else $error("sample taken without sample clock");
    a_ready_fall_cause: assert property ($fell(adc_ready_out) |-> $past(adc_valid_in) || $past(adc_valid_in, 2))
        else $error("capture buffer filled without input");
endmodule
bind codec_host_port codec_host_port_checker #(.INIT_COUNT(INIT_COUNT)) u_checker (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n_in), .rd_n_in(rd_n_in),
    .wr_n_in(wr_n_in), .data_out(data_out), .data_oe_out(data_oe_out), .irq_out(irq_out),
    .playback_dma_request_out(playback_dma_request_out), .adc_valid_in(adc_valid_in),
    .adc_ready_out(adc_ready_out), .dac_strobe_in(dac_strobe_in),
    .dac_mute_out(dac_mute_out), .playback_wrap_out(playback_wrap_out));

/* dv/tb_codec_host_port.sv */
// Self-checking bench for the codec host register port
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; $display("mismatch t=%0t got %h exp %h", $time, got, exp); end end
module tb_codec_host_port;
    import codec_port_pkg::*;
    logic        clock_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [1:0]  addr;
    logic        cs_n, rd_n, wr_n, data_oe, irq, playback_dma_request, capture_dma_request, adc_ready, mute, wrap;
    logic [7:0]  hdata, rdata, q, v;
    logic        power_down_in = 1'b1, adc_valid_in = 1'b0, dac_strobe_in = 1'b0, cack = 1'b0;
    logic [31:0] adc_sample_in = 32'h0, dac_sample, smp;
    int          seed = 59165, mismatches = 0, samples_checked = 0, cycles = 0, i;
    // Byte masks of the defined bits in indirect registers 0 to 7
    logic [7:0]  mask [0:7] = '{8'hef, 8'hef, 8'h9f, 8'h9f, 8'h9f, 8'h9f, 8'hbf, 8'hbf};
    always #2.5 clock_in = ~clock_in;
    host_bus_model u_host (.clock_in(clock_in), .rd_data_in(rdata), .addr_out(addr),
        .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .data_out(hdata));
    codec_host_port #(.TICK_DIV(4), .INIT_COUNT(4)) u_dut (.clock_in(clock_in),
        .reset_n_in(reset_n_in), .addr_in(addr), .cs_n_in(cs_n), .rd_n_in(rd_n),
        .wr_n_in(wr_n), .data_in(hdata), .data_out(rdata), .data_oe_out(data_oe),
        .irq_out(irq), .playback_dma_request_out(playback_dma_request), .capture_dma_request_out(capture_dma_request),
        .playback_dma_ack_in(1'b0), .capture_dma_ack_in(cack), .power_down_in(power_down_in),
        .adc_valid_in(adc_valid_in), .adc_ready_out(adc_ready), .adc_sample_in(adc_sample_in),
        .dac_strobe_in(dac_strobe_in), .dac_sample_out(dac_sample), .dac_mute_out(mute),
        .playback_wrap_out(wrap));
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        logic [7:0] unused;
        u_host.bus_cycle(1'b1, a, d, unused);
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        u_host.bus_cycle(1'b0, a, 8'h00, d);
    endtask
    // Indirect access, index written with the unlock bit set
    task automatic wri(input logic [4:0] idx, input logic [7:0] d);
        wr(ADDR_INDEX, {3'b010, idx});
        wr(ADDR_WINDOW, d);
    endtask
    task automatic rdi(input logic [4:0] idx, output logic [7:0] d);
        wr(ADDR_INDEX, {3'b010, idx});
        rd(ADDR_WINDOW, d);
    endtask
    task automatic wait_irq(input int limit);
        for (int n = 0; n < limit && irq !== 1'b1; n++) @(posedge clock_in);
    endtask
    task automatic pulse_dac();
        @(posedge clock_in);
        #1 dac_strobe_in = 1'b1;
        @(posedge clock_in);
        #1 dac_strobe_in = 1'b0;
        repeat (8) @(posedge clock_in);
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog against a hung handshake
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge clock_in);
        #1 reset_n_in = 1'b1;
        repeat (10) @(posedge clock_in);
        wr(ADDR_INDEX, 8'h0a);
        rd(ADDR_WINDOW, q);
        `CHECK(q, INIT_READ)
        #1 power_down_in = 1'b0;
        repeat (10) @(posedge clock_in);
        rd(ADDR_INDEX, q);
        `CHECK(q & 8'hef, INDEX_RESET)
        // Mixer registers with random contents
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            wri(i[4:0], v);
            rdi(i[4:0], q);
            `CHECK(q & mask[i], v & mask[i])
        end
        wri(IDX_MODEID, 8'h40);
        wri(IDX_TMR_LO, 8'h02);
        wri(IDX_TMR_HI, 8'h00);
        rdi(IDX_TMR_LO, q);
        `CHECK(q, 8'h02)
        // Locked format write is dropped, unlocked one lands
        rdi(IDX_FORMAT, v);
        wr(ADDR_INDEX, {3'b000, IDX_FORMAT});
        `CHECK(mute, 1'b0)
        wr(ADDR_WINDOW, ~v);
        rd(ADDR_WINDOW, q);
        `CHECK(q, v)
        wri(IDX_FORMAT, ~v);
        rdi(IDX_FORMAT, q);
        `CHECK(q, ~v)
        `CHECK(mute, 1'b1)
        // Timer rollover raises the interrupt, status write clears it
        wri(IDX_PINCTL, 8'h02);
        wri(IDX_FEATEN, 8'h40);
        wait_irq(300);
        `CHECK(irq, 1'b1)
        wri(IDX_FEATEN, 8'h00);
        rdi(IDX_FEATSTAT, q);
        `CHECK(q[BIT_TI], 1'b1)
        rd(ADDR_STATUS, q);
        `CHECK(q[0], 1'b1)
        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, q);
        `CHECK({q[0], irq}, 2'b00)
        // Masked pin while the flag still records the event
        wri(IDX_PINCTL, 8'h00);
        wri(IDX_FEATEN, 8'h40);
        repeat (80) @(posedge clock_in);
        `CHECK(irq, 1'b0)
        wri(IDX_FEATEN, 8'h00);
        rd(ADDR_STATUS, q);
        `CHECK(q[0], 1'b1)
        wri(IDX_FEATSTAT, 8'h00);
        rd(ADDR_STATUS, q);
        `CHECK(q[0], 1'b0)
        // Playback sample by bytes, a surplus byte, then an underrun
        wri(IDX_CONFIG, 8'hc3);
        smp = $random(seed);
        for (i = 0; i < 5; i++) wr(ADDR_DATA, (i < 4) ? smp[8*i +: 8] : ~smp[7:0]);
        rd(ADDR_STATUS, q);
        `CHECK(q[1], 1'b0)
        pulse_dac();
        `CHECK(dac_sample, smp)
        `CHECK(playback_dma_request, 1'b1)
        pulse_dac();
        `CHECK(dac_sample, smp)
        // Capture sample read by bytes, the pointer holding at the last
        smp = $random(seed);
        #1 adc_sample_in = smp;
        adc_valid_in = 1'b1;
        for (i = 0; i < 50 && adc_ready !== 1'b1; i++) @(posedge clock_in);
        @(posedge clock_in);
        #1 adc_valid_in = 1'b0;
        repeat (8) @(posedge clock_in);
        `CHECK(capture_dma_request, 1'b1)
        rd(ADDR_STATUS, q);
        for (i = 0; i < 5; i++) begin
            rd(ADDR_DATA, q);
            `CHECK(q, smp[8*((i < 4) ? i : 3) +: 8])
        end
        // Overfill the capture buffer
        #1 adc_valid_in = 1'b1;
        for (i = 0; i < 6; i++) begin
            adc_sample_in = $random(seed);
            @(posedge clock_in);
            #1;
        end
        adc_valid_in = 1'b0;
        rd(ADDR_STATUS, q);
        rd(ADDR_DATA, q);
        `CHECK(q, smp[7:0])
        rdi(IDX_ERRSTAT, q);
        `CHECK(q[4], 1'b1)
        // One capture transfer rolls the count over; inhibit then stops requests
        @(posedge clock_in);
        #1 cack = 1'b1;
        @(posedge clock_in);
        #1 cack = 1'b0;
        repeat (4) @(posedge clock_in);
        rd(ADDR_STATUS, q);
        `CHECK(q[0], 1'b1)
        wr(ADDR_INDEX, 8'h20);
        `CHECK(capture_dma_request, 1'b0)
        print_verdict();
    end
endmodule
